/* File: design/mcs_byte_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mcs_byte_if;
  logic [7:0]  data;
  logic        valid;
  logic        init;
  logic        last;
  logic [15:0] crc;

  modport src  (output data, valid, init, last);
  modport sink (input data, valid, init, output crc);
  modport mon  (input last, crc);
endinterface : mcs_byte_if
`default_nettype wire

/* File: design/mcs_crc16.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_crc16 (
  // Clock and reset
  input  wire logic     pclk,
  input  wire logic     presetn,
  // Byte stream in, checksum out
  mcs_byte_if.sink      bus
);

  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // One byte, most significant bit first
  function automatic logic [15:0] mcs_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[15] ^ d[i];
      r  = {r[14:0], 1'b0} ^ (fb ? mcs_pkg::CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : mcs_crc_byte

  // Seed wins over data so a restart never mixes runs
  assign crc_next = bus.init  ? mcs_pkg::CRC_INIT :
                    bus.valid ? mcs_crc_byte(crc_reg, bus.data) : crc_reg;
  assign bus.crc  = crc_reg;

  // Checksum register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_reg <= mcs_pkg::CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

endmodule : mcs_crc16
`default_nettype wire

/* File: design/mcs_flash_fetch.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_flash_fetch (
  // Clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // Control from the scanner
  input  wire logic                               start,
  input  wire logic                               abort,
  input  wire logic                               run,
  input  wire logic                               prio,
  input  wire logic [mcs_pkg::FLASH_WORD_AW-1:0]  end_word,
  // Flash and CPU fetch path
  input  wire logic                               cpu_flash_req,
  input  wire logic [15:0]                        flash_rdata,
  output logic                                    flash_rd,
  output logic [mcs_pkg::FLASH_WORD_AW-1:0]       flash_addr,
  output logic                                    cpu_wait,
  // Byte stream to the checksum
  mcs_byte_if.src                                 bus
);

  logic                              active_reg;
  logic [1:0]                        phase_reg;
  logic [mcs_pkg::FLASH_WORD_AW-1:0] addr_reg;
  logic [7:0]                        byte_reg;
  logic [7:0]                        hi_reg;
  logic                              valid_reg;
  logic                              hi_pend_reg;
  logic                              final_reg;
  logic                              last_reg;
  wire                               closing;
  wire                               issue;

  // Sleep only pauses new fetches, so a word in flight is never lost
  assign closing = hi_pend_reg && final_reg;
  assign issue   = active_reg && run && (phase_reg == mcs_pkg::PHASE_ISSUE) && !closing
                   && (prio || !cpu_flash_req);
  assign bus.data  = byte_reg;
  assign bus.valid = valid_reg;
  assign bus.last  = last_reg;
  assign bus.init  = start;

  // Three-phase fetch: issue, wait, capture; low byte then high byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg  <= 1'b0;
      phase_reg   <= mcs_pkg::PHASE_ISSUE;
      addr_reg    <= '0;
      flash_rd    <= 1'b0;
      flash_addr  <= '0;
      cpu_wait    <= 1'b0;
      byte_reg    <= 8'h00;
      hi_reg      <= 8'h00;
      valid_reg   <= 1'b0;
      hi_pend_reg <= 1'b0;
      final_reg   <= 1'b0;
      last_reg    <= 1'b0;
    end else if (start || abort) begin
      active_reg  <= start;
      phase_reg   <= mcs_pkg::PHASE_ISSUE;
      addr_reg    <= '0;
      flash_rd    <= 1'b0;
      cpu_wait    <= 1'b0;
      valid_reg   <= 1'b0;
      hi_pend_reg <= 1'b0;
      final_reg   <= 1'b0;
      last_reg    <= 1'b0;
    end else begin
      flash_rd  <= issue;
      cpu_wait  <= issue && !prio;
      valid_reg <= 1'b0;
      last_reg  <= 1'b0;
      if (issue) begin
        flash_addr <= addr_reg;
      end
      case (phase_reg)
        mcs_pkg::PHASE_ISSUE: begin
          if (issue) begin
            phase_reg <= mcs_pkg::PHASE_WAIT;
          end
        end
        mcs_pkg::PHASE_WAIT: begin
          phase_reg <= mcs_pkg::PHASE_CAPTURE;
        end
        mcs_pkg::PHASE_CAPTURE: begin
          phase_reg   <= mcs_pkg::PHASE_ISSUE;
          byte_reg    <= flash_rdata[7:0];
          hi_reg      <= flash_rdata[15:8];
          valid_reg   <= 1'b1;
          hi_pend_reg <= 1'b1;
          final_reg   <= (flash_addr == end_word);
          addr_reg    <= addr_reg + 1'b1;
        end
        default: begin
          phase_reg <= mcs_pkg::PHASE_ISSUE;
        end
      endcase
      if (hi_pend_reg) begin
        byte_reg    <= hi_reg;
        valid_reg   <= 1'b1;
        hi_pend_reg <= 1'b0;
        last_reg    <= final_reg;
        if (final_reg) begin
          active_reg <= 1'b0;
        end
      end
    end
  end

endmodule : mcs_flash_fetch
`default_nettype wire

/* File: design/mcs_memory_checksum_scanner.sv */
// Operation
// - Failed startup scan keeps CPU from running.
// - After startup scan, control shows background, enabled.
// - Continuous mode restarts on pass, stops on fail.
// - Priority mode stalls CPU until check ends.
// - Background single check fetches when CPU idle.
// - Collision delays CPU exactly one cycle.
// - Priority or startup fetches every third cycle.
// - Section select picks flash, boot+app, boot.
// - Failure clears pass flag, raises sticky interrupt.
// - Interrupt enable set only idle, system reset clears.
// - After interrupt, control writes are ignored.
// - Mode/section writes ignored when busy or interrupted.
// - Reset strobe clears registers, except interrupt enable, one cycle later.
// - Strobe refused while busy if interrupt enabled.
// - Enable write starts check; bit stays one.
// - Clearing enable stops after section end.
// - Halt during CPU sleep, resume on wake.
// - Pending priority check runs right after wake.
// - Status read-only, resets to pass set.
// - Failure interrupt ignores global interrupt enable.
// - Polynomial x16 plus x12 plus x5 plus one.
// - Checksum seeded with all ones each check.
// - Bytes ascending, most significant bit first.
// - Pass flag zero while enabled and busy.
`timescale 1ns/1ps
`default_nettype none
module mcs_memory_checksum_scanner (
  // Clock and reset
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [3:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Flash read port
  output logic                                    flash_rd,
  output logic [mcs_pkg::FLASH_WORD_AW-1:0]       flash_addr,
  input  wire logic [15:0]                        flash_rdata,
  // CPU side
  input  wire logic                               cpu_flash_req,
  input  wire logic                               cpu_sleep,
  output logic                                    cpu_wait,
  output logic                                    cpu_stall,
  output logic                                    nmi_req,
  // Startup configuration
  input  wire logic                               startup_scan_enable,
  input  wire logic [1:0]                         startup_section_select,
  input  wire logic [7:0]                         boot_end_setting,
  input  wire logic [7:0]                         application_end_setting
);

  // Byte stream, fetch to checksum
  mcs_byte_if byte_bus ();

  // Sequencer
  mcs_pkg::mcs_state_e               state_reg;
  mcs_pkg::mcs_state_e               state_next;

  // Control fields
  logic                              enable_reg;
  logic                              enable_next;
  logic                              fail_interrupt_enable_reg;
  logic                              fail_interrupt_enable_next;

  // Mode and section
  logic [1:0]                        mode_reg;
  logic [1:0]                        mode_next;
  logic [1:0]                        section_select_reg;
  logic [1:0]                        section_select_next;

  // Status and request
  logic                              busy_reg;
  logic                              busy_next;
  logic                              ok_reg;
  logic                              ok_next;
  logic                              nmi_reg;
  logic                              nmi_next;

  // Run bookkeeping
  logic                              start_pend_reg;
  logic                              start_pend_next;
  logic                              startup_reg;
  logic                              startup_next;
  logic                              boot_fail_reg;
  logic                              boot_fail_next;
  logic                              init_seen_reg;

  // Strobe and stall
  logic                              strobe_reg;
  logic                              hold_next;
  logic [mcs_pkg::FLASH_WORD_AW-1:0] end_word;

  // Last word of the selected section; reserved code falls back to full flash
  function automatic logic [mcs_pkg::FLASH_WORD_AW-1:0] mcs_end_word(
      input logic [1:0] sel, input logic [7:0] boot_end, input logic [7:0] app_end);
    logic [15:0] last_byte;
    case (sel)
      mcs_pkg::SRC_BOOT:    last_byte = {boot_end, 8'h00} - mcs_pkg::SECTION_ONE_BYTE;
      mcs_pkg::SRC_BOOT_PLUS_APPLICATION: last_byte = {app_end, 8'h00} - mcs_pkg::SECTION_ONE_BYTE;
      default:              last_byte = mcs_pkg::LAST_FLASH_ADDRESS;
    endcase
    return last_byte[mcs_pkg::FLASH_WORD_AW:1];
  endfunction : mcs_end_word

  // APB decode; a write lands on the edge that samples pready high
  wire       apb_setup   = psel && penable && !pready;
  wire       apb_take    = psel && penable && pready;
  wire       hit_ctrl    = (paddr == mcs_pkg::ADDR_CONTROL);
  wire       hit_ms      = (paddr == mcs_pkg::ADDR_MODE_SOURCE);
  wire       hit_stat    = (paddr == mcs_pkg::ADDR_STATUS);
  wire       addr_hit    = hit_ctrl || hit_ms || hit_stat;

  // Bus writes, one per writable register; status has none
  wire       wr_ctrl     = apb_take && pwrite && hit_ctrl;
  wire       wr_ms       = apb_take && pwrite && hit_ms;
  wire       ctrl_open   = wr_ctrl && !nmi_reg;
  wire       strobe_take = ctrl_open && pwdata[mcs_pkg::CTRL_RESET_BIT]
                           && (!fail_interrupt_enable_reg || !busy_reg);
  wire       ctrl_plain  = ctrl_open && !pwdata[mcs_pkg::CTRL_RESET_BIT];
  wire       ms_open     = wr_ms && !busy_reg && !nmi_reg;

  // Enable and section pins read once, first edge
  wire       startup_now = !init_seen_reg && startup_scan_enable;

  wire       launch      = start_pend_reg && !cpu_sleep && (state_reg == mcs_pkg::ST_IDLE)
                           && !strobe_reg;

  wire       crc_pass    = (byte_bus.crc == mcs_pkg::CRC_RESIDUE);
  // Startup paces like priority
  wire       prio_pace   = startup_reg || (mode_reg == mcs_pkg::MODE_PRIORITY);

  // Read mux; upper bits read zero
  wire [7:0] ctrl_rd     = {6'h00, fail_interrupt_enable_reg, enable_reg};
  wire [7:0] ms_rd       = {2'h0, mode_reg, 2'h0, section_select_reg};
  wire [7:0] stat_rd     = {6'h00, ok_reg, busy_reg};
  wire [7:0] rd_value    = hit_ctrl ? ctrl_rd :
                           hit_ms   ? ms_rd   :
                           hit_stat ? stat_rd : 8'h00;

  assign end_word = mcs_end_word(section_select_reg, boot_end_setting, application_end_setting);

  // Control and status next-state; later writes override earlier ones
  always_comb begin
    state_next                 = state_reg;
    enable_next                = enable_reg;
    fail_interrupt_enable_next = fail_interrupt_enable_reg;
    mode_next                  = mode_reg;
    section_select_next        = section_select_reg;
    busy_next                  = busy_reg;
    ok_next                    = ok_reg;
    nmi_next                   = nmi_reg;
    start_pend_next            = start_pend_reg;
    startup_next               = startup_reg;
    boot_fail_next             = boot_fail_reg;

    if (startup_now) begin
      enable_next         = 1'b1;
      mode_next           = mcs_pkg::MODE_BACKGROUND;
      section_select_next = startup_section_select;
      start_pend_next     = 1'b1;
      busy_next           = 1'b1;
      ok_next             = 1'b0;
      startup_next        = 1'b1;
    end

    // Sequencer steps
    case (state_reg)
      mcs_pkg::ST_IDLE: begin
        if (launch) begin
          state_next      = mcs_pkg::ST_SCAN;
          start_pend_next = 1'b0;
        end
      end
      mcs_pkg::ST_SCAN: begin
        if (byte_bus.last) begin
          state_next = mcs_pkg::ST_EVAL;
        end
      end
      mcs_pkg::ST_EVAL: begin
        state_next = mcs_pkg::ST_IDLE;
        if (!crc_pass) begin
          ok_next        = 1'b0;
          nmi_next       = nmi_reg || fail_interrupt_enable_reg;
          busy_next      = 1'b0;
          boot_fail_next = boot_fail_reg || startup_reg;
          startup_next   = 1'b0;
        end else if (mode_reg == mcs_pkg::MODE_CONTINUOUS && enable_reg && !startup_reg) begin
          start_pend_next = 1'b1;
        end else begin
          busy_next    = 1'b0;
          ok_next      = 1'b1;
          startup_next = 1'b0;
        end
      end
      default: begin
        state_next = mcs_pkg::ST_IDLE;
      end
    endcase

    // Bus writes come after, so they win
    if (ctrl_plain) begin
      // cleared enable ends at section end
      enable_next = pwdata[mcs_pkg::CTRL_ENABLE_BIT];
      if (pwdata[mcs_pkg::CTRL_ENABLE_BIT] && !busy_reg) begin
        start_pend_next = 1'b1;
        busy_next       = 1'b1;
        ok_next         = 1'b0;
      end
      if (pwdata[mcs_pkg::CTRL_FAIL_INTERRUPT_ENABLE_BIT] && !busy_reg) begin
        fail_interrupt_enable_next = 1'b1;
      end
    end

    if (ms_open) begin
      mode_next           = pwdata[mcs_pkg::MODE_LSB +: 2];
      section_select_next = pwdata[mcs_pkg::SRC_LSB +: 2];
    end

    if (strobe_reg) begin
      state_next          = mcs_pkg::ST_IDLE;
      enable_next         = mcs_pkg::CONTROL_RESET[mcs_pkg::CTRL_ENABLE_BIT];
      mode_next           = mcs_pkg::MODE_SOURCE_RESET[mcs_pkg::MODE_LSB +: 2];
      section_select_next = mcs_pkg::MODE_SOURCE_RESET[mcs_pkg::SRC_LSB +: 2];
      busy_next           = 1'b0;
      ok_next             = 1'b0;
      start_pend_next     = 1'b0;
      startup_next        = 1'b0;
    end

    hold_next = boot_fail_next || (busy_next && (startup_next || mode_next == mcs_pkg::MODE_PRIORITY));
  end

  // Control and status registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg                 <= mcs_pkg::ST_IDLE;
      enable_reg                <= mcs_pkg::CONTROL_RESET[mcs_pkg::CTRL_ENABLE_BIT];
      fail_interrupt_enable_reg <= mcs_pkg::CONTROL_RESET[mcs_pkg::CTRL_FAIL_INTERRUPT_ENABLE_BIT];
      mode_reg                  <= mcs_pkg::MODE_SOURCE_RESET[mcs_pkg::MODE_LSB +: 2];
      section_select_reg        <= mcs_pkg::MODE_SOURCE_RESET[mcs_pkg::SRC_LSB +: 2];
      busy_reg                  <= mcs_pkg::STATUS_RESET[mcs_pkg::STAT_BUSY_BIT];
      ok_reg                    <= mcs_pkg::STATUS_RESET[mcs_pkg::STAT_OK_BIT];
      nmi_reg                   <= 1'b0;
      start_pend_reg            <= 1'b0;
      startup_reg               <= 1'b0;
      boot_fail_reg             <= 1'b0;
      init_seen_reg             <= 1'b0;
      strobe_reg                <= 1'b0;
      cpu_stall                 <= 1'b0;
      nmi_req                   <= 1'b0;
    end else begin
      state_reg                 <= state_next;
      enable_reg                <= enable_next;
      fail_interrupt_enable_reg <= fail_interrupt_enable_next;
      mode_reg                  <= mode_next;
      section_select_reg        <= section_select_next;
      busy_reg                  <= busy_next;
      ok_reg                    <= ok_next;
      nmi_reg                   <= nmi_next;
      start_pend_reg            <= start_pend_next;
      startup_reg               <= startup_next;
      boot_fail_reg             <= boot_fail_next;
      // Startup enable and section pins are read once only; the end settings feed end_word all the time
      init_seen_reg             <= 1'b1;
      strobe_reg                <= strobe_take;
      cpu_stall                 <= hold_next;
      nmi_req                   <= nmi_next;
    end
  end

  // APB answer: one wait state, so read data and error come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      // Unmapped offsets: error, no write
      pslverr <= apb_setup && !addr_hit;
      if (apb_setup) begin
        prdata <= {24'h00_0000, rd_value};
      end
    end
  end

  // Flash fetch sequencer; sleep pauses it in place
  mcs_flash_fetch u_fetch (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (launch),
    .abort         (strobe_reg),
    .run           (!cpu_sleep),
    .prio          (prio_pace),
    .end_word      (end_word),
    .cpu_flash_req (cpu_flash_req),
    .flash_rdata   (flash_rdata),
    .flash_rd      (flash_rd),
    .flash_addr    (flash_addr),
    .cpu_wait      (cpu_wait),
    .bus           (byte_bus.src)
  );

  mcs_crc16 u_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (byte_bus.sink)
  );

endmodule : mcs_memory_checksum_scanner
`default_nettype wire

/* File: design/mcs_pkg.sv */
`default_nettype none
package mcs_pkg;

  // Register indices and APB byte addresses (one aligned word each)
  localparam int         REG_IDX_CONTROL     = 0;
  localparam int         REG_IDX_MODE_SOURCE = 1;
  localparam int         REG_IDX_STATUS      = 2;
  localparam logic [3:0] ADDR_CONTROL        = 4'(REG_IDX_CONTROL * 4);
  localparam logic [3:0] ADDR_MODE_SOURCE    = 4'(REG_IDX_MODE_SOURCE * 4);
  localparam logic [3:0] ADDR_STATUS         = 4'(REG_IDX_STATUS * 4);

  // Field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FAIL_INTERRUPT_ENABLE_BIT  = 1;
  localparam int CTRL_RESET_BIT  = 7;
  localparam int MODE_LSB        = 4;
  localparam int SRC_LSB         = 0;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_OK_BIT     = 1;

  // Values after reset
  localparam logic [7:0] CONTROL_RESET     = 8'h00;
  localparam logic [7:0] MODE_SOURCE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET      = 8'h02;

  // Access modes and section codes
  localparam logic [1:0] MODE_PRIORITY   = 2'h0;
  localparam logic [1:0] MODE_BACKGROUND = 2'h2;
  localparam logic [1:0] MODE_CONTINUOUS = 2'h3;
  localparam logic [1:0] SRC_FLASH       = 2'h0;
  localparam logic [1:0] SRC_BOOT_PLUS_APPLICATION     = 2'h1;
  localparam logic [1:0] SRC_BOOT        = 2'h2;

  // Checksum generator
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // Flash geometry and fetch pacing (one word every third cycle)
  localparam int          FLASH_WORD_AW      = 13;
  localparam logic [15:0] LAST_FLASH_ADDRESS = 16'h3FFF;
  localparam logic [15:0] SECTION_ONE_BYTE   = 16'h0001;
  localparam logic [1:0]  PHASE_ISSUE        = 2'h0;
  localparam logic [1:0]  PHASE_WAIT         = 2'h1;
  localparam logic [1:0]  PHASE_CAPTURE      = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_EVAL} mcs_state_e;

endpackage : mcs_pkg
`default_nettype wire

/* File: sim/mcs_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_flash_model (
  // Clock and read port
  input  wire logic        pclk,
  input  wire logic        flash_rd,
  input  wire logic [12:0] flash_addr,
  input  wire logic [15:0] csum,
  output logic      [15:0] flash_rdata
);
  function automatic logic [15:0] word_at(input int w);
    return (w == 127) ? {csum[7:0], csum[15:8]} : 16'(w * 291 + 17767);
  endfunction : word_at
  // Word one cycle after read; idle bus flips so stale data never passes
  always @(posedge pclk) begin
    flash_rdata <= flash_rd ? word_at(int'(flash_addr)) : ~flash_rdata;
  end
  initial flash_rdata = 16'h0000;
endmodule : mcs_flash_model
`default_nettype wire

/* File: sim/mcs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_sva (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Register bus
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [3:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  // Flash and CPU
  input wire logic       flash_rd,
  input wire logic       cpu_flash_req,
  input wire logic       cpu_sleep,
  input wire logic       cpu_wait,
  input wire logic       cpu_stall,
  input wire logic       nmi_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("ready not a single pulse");
  property p_err; pready |-> pslverr == (paddr > 4'h8 || paddr[1:0] != 2'h0); endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_pace; flash_rd |=> !flash_rd [*2]; endproperty
  a_pace: assert property (p_pace) else $error("fetches too close");
  property p_wait; cpu_wait |-> flash_rd && !cpu_stall; endproperty
  a_wait: assert property (p_wait) else $error("cpu wait without fetch");
  property p_bg; flash_rd && !cpu_stall |-> !$past(cpu_flash_req); endproperty
  a_bg: assert property (p_bg) else $error("fetch while cpu uses flash");
  property p_sleep; cpu_sleep |=> !flash_rd; endproperty
  a_sleep: assert property (p_sleep) else $error("fetch during sleep");
  property p_nmi; nmi_req |=> nmi_req; endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt request dropped");
  // Main scenarios reached
  c_nmi: cover property ($rose(nmi_req));
  c_wait: cover property (cpu_wait);
  c_err: cover property (pslverr);
endmodule : mcs_sva
bind mcs_memory_checksum_scanner mcs_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .flash_rd(flash_rd),
  .cpu_flash_req(cpu_flash_req), .cpu_sleep(cpu_sleep), .cpu_wait(cpu_wait),
  .cpu_stall(cpu_stall), .nmi_req(nmi_req));
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, st_en;
  logic        flash_rd, cpu_flash_req, cpu_sleep, cpu_wait, cpu_stall, nmi_req, req_on;
  logic [3:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] flash_addr;
  logic [15:0] flash_rdata, csum, good;
  logic [7:0]  rd;
  int          failures, tests_run;
  int          waits = 0;
  mcs_memory_checksum_scanner DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .cpu_flash_req(cpu_flash_req), .cpu_sleep(cpu_sleep),
    .cpu_wait(cpu_wait), .cpu_stall(cpu_stall), .nmi_req(nmi_req),
    .startup_scan_enable(st_en), .startup_section_select(2'h2),
    .boot_end_setting(8'h01), .application_end_setting(8'h02));
  mcs_flash_model u_flash (.pclk(pclk), .flash_rd(flash_rd), .flash_addr(flash_addr),
    .csum(csum), .flash_rdata(flash_rdata));
  // Clock, and a CPU that wants flash every other cycle when asked
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) cpu_flash_req <= req_on & ~cpu_flash_req;
  // Count CPU wait pulses
  always @(posedge pclk) if (cpu_wait === 1'b1) waits++;
  function automatic logic [15:0] crc_of();
    logic [15:0] c;
    logic [15:0] w;
    c = 16'hFFFF;
    for (int i = 0; i < 254; i++) begin
      w = u_flash.word_at(i / 2);
      for (int b = 7; b >= 0; b--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ ((i % 2) ? w[8+b] : w[b])) ? 16'h1021 : 16'h0000);
    end
    return c;
  endfunction : crc_of
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    st_en   <= s;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset
  task automatic wait_idle();
    do apb(1'b0, 4'h8, 8'h00); while (rd[0] === 1'b1);
  endtask : wait_idle
  task automatic t_regs();
    apb(1'b1, 4'h8, 8'hFF);
    apb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h02);
    apb(1'b0, 4'hC, 8'h00);
    chk({7'h00, err}, 8'h01);
    $display("test regs done");
  endtask : t_regs
  task automatic t_prio();
    csum = good;
    apb(1'b1, 4'h4, 8'h02);
    apb(1'b1, 4'h0, 8'h01);
    apb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h01);
    chk({7'h00, cpu_stall}, 8'h01);
    apb(1'b1, 4'h4, 8'h31);
    wait_idle();
    chk(rd, 8'h02);
    apb(1'b0, 4'h4, 8'h00);
    chk(rd, 8'h02);
    apb(1'b0, 4'h0, 8'h00);
    chk(rd, 8'h01);
    chk({7'h00, waits == 0}, 8'h01);
    $display("test priority done");
  endtask : t_prio
  task automatic t_fail();
    csum = ~good;
    req_on <= 1'b1;
    apb(1'b1, 4'h4, 8'h22);
    apb(1'b1, 4'h0, 8'h02);
    apb(1'b1, 4'h0, 8'h03);
    cpu_sleep <= 1'b1;
    repeat (30) @(posedge pclk);
    cpu_sleep <= 1'b0;
    wait_idle();
    chk(rd, 8'h00);
    chk({7'h00, nmi_req}, 8'h01);
    chk({7'h00, waits > 0}, 8'h01);
    apb(1'b1, 4'h0, 8'h80);
    apb(1'b0, 4'h0, 8'h00);
    chk(rd, 8'h03);
    req_on <= 1'b0;
    $display("test failure done");
  endtask : t_fail
  task automatic t_strobe();
    csum = good;
    apb(1'b1, 4'h4, 8'h32);
    apb(1'b1, 4'h0, 8'h01);
    repeat (1200) @(posedge pclk);
    apb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h01);
    apb(1'b1, 4'h0, 8'h80);
    apb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h00);
    apb(1'b0, 4'h4, 8'h00);
    chk(rd, 8'h00);
    $display("test strobe done");
  endtask : t_strobe
  task automatic t_start();
    csum = ~good;
    do_reset(1'b1);
    repeat (900) @(posedge pclk);
    chk({7'h00, cpu_stall}, 8'h01);
    csum = good;
    do_reset(1'b1);
    @(posedge pclk);
    while (cpu_stall !== 1'b0) @(posedge pclk);
    apb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h02);
    apb(1'b0, 4'h0, 8'h00);
    chk(rd, 8'h01);
    apb(1'b0, 4'h4, 8'h00);
    chk(rd, 8'h22);
    $display("test startup done");
  endtask : t_start
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, req_on, cpu_sleep, st_en} = 6'h00;
    {paddr, pwdata, csum, failures, tests_run} = '0;
    presetn = 1'b0;
    good = crc_of();
    do_reset(1'b0);
    t_regs();
    t_prio();
    t_fail();
    do_reset(1'b0);
    t_strobe();
    t_start();
    test_done();
  end
endmodule : tb
`default_nettype wire
